// File: inc/adc_irq_pkg.sv
// constants shared by the converter interrupt unit and its limit comparator
package adc_irq_pkg;

  // word addresses seen on the upper four address lines
  localparam logic [3:0] ENABLE_ADDR = 4'h9;
  localparam logic [3:0] STATUS_ADDR = 4'hA;
  localparam logic [3:0] LIMIT_ADDR = 4'hD;

  // source count and flag positions
  localparam int NUM_SRC = 8;
  localparam int SRC_WATCHDOG = 0;
  localparam int SRC_MATCH = 1;
  localparam int SRC_FIFO = 2;
  localparam int SRC_SHORTCAL = 3;
  localparam int SRC_FULLCAL = 4;
  localparam int SRC_PAUSE = 5;
  localparam int SRC_SUPPLY = 6;
  localparam int SRC_WAKE = 7;

  // field positions inside the enable and status words
  localparam int MATCH_LSB = 8;
  localparam int MATCH_W = 3;
  localparam int THRESH_LSB = 11;
  localparam int THRESH_W = 5;
  localparam int LIMIT2_LSB = 8;

  // values after reset
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // synchroniser after reset: strobes idle high, supply good
  localparam logic [25:0] PIN_IDLE = 26'h0000007;

  // wake-up settling delay, least time, rounded up to whole cycles
  localparam int CLOCK_KHZ = 10000;
  localparam int SETTLE_TIME_US = 10000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_US * CLOCK_KHZ + 999) / 1000;

  // bus handshake states
  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_state_type;

endpackage : adc_irq_pkg

// File: src/limit_compare.sv
// watchdog limit comparison and the per-instruction limit status word
`timescale 1ns/1ps
`default_nettype none

module limit_compare
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // one watchdog comparison result
  input wire logic cmpValid,
  input wire logic signed [8:0] sample,
  input wire logic signed [8:0] limitOne,
  input wire logic dirOne,
  input wire logic signed [8:0] limitTwo,
  input wire logic dirTwo,
  input wire logic [2:0] cmpInstr,
  // clearing
  input wire logic clearRead,
  input wire logic clearReset,
  // results
  output logic crossHit,
  output logic [15:0] limitStatus
);

  ////////////////////////////////////////////////////////////////////////
  // direction one means above the limit, zero means below it
  function automatic logic crossed(input logic signed [8:0] s,
                                   input logic signed [8:0] lim,
                                   input logic dir);
    crossed = dir ? (s > lim) : (s < lim);
  endfunction : crossed

  logic [15:0] status_r; // limit one in low byte, limit two in high byte
  logic [15:0] status_nxt;
  logic hit_r; // one-cycle pulse toward the interrupt flags
  logic hit_nxt;
  logic oneHit;
  logic twoHit;

  ////////////////////////////////////////////////////////////////////////
  // both limits are checked against the same sample in the same cycle
  always_comb
  begin
    oneHit = cmpValid && crossed(sample, limitOne, dirOne); // [RULE6]
    twoHit = cmpValid && crossed(sample, limitTwo, dirTwo); // [RULE6]
    status_nxt = status_r;
    if (clearReset || clearRead)
    begin
      status_nxt = adc_irq_pkg::LIMIT_RESET;
    end
    // a crossing in the clearing cycle still lands
    if (oneHit)
    begin
      status_nxt[cmpInstr] = 1'b1; // [RULE7]
    end
    if (twoHit)
    begin
      status_nxt[adc_irq_pkg::LIMIT2_LSB + int'(cmpInstr)] = 1'b1; // [RULE7]
    end
    hit_nxt = oneHit || twoHit;
  end

  // register the limit word and the crossing pulse
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      status_r <= adc_irq_pkg::LIMIT_RESET;
      hit_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign crossHit = hit_r;
  assign limitStatus = status_r;

endmodule : limit_compare
`default_nettype wire

// File: src/adc_interrupt_unit.sv
// interrupt unit of the sequenced converter: flags, enables, parallel bus
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: eight equal sources drive one interrupt pin
// RULE2: interrupt pin low, with transfer request
// RULE3: flags set regardless of enable bits
// RULE4: status read or device reset clears flags
// RULE5: host reads status after enable writes
// RULE6: watchdog crossing sets source zero
// RULE7: limit status records limit and instruction
// RULE8: pointer match sets source one pre-execution
// RULE9: match zero skips first fetch
// RULE10: fifo count equals threshold sets two
// RULE11: short auto-zero done sets three
// RULE12: full calibration done sets four
// RULE13: paused instruction fetch sets five
// RULE14: low analog supply sets six
// RULE15: standby release sets seven after settling
// RULE16: enable bits gate flags onto pin
// RULE17: status shows instruction pointer
// RULE18: status shows fifo conversion count
// RULE19: match interrupt never stops sequencer
// RULE20: enable at 1001, status at 1010
// RULE21: host reads status to find source
// RULE22: configuration reset clears all flags
// RULE23: pin asserted while flags and enables overlap
// RULE24: event during clearing read is kept
module adc_interrupt_unit
#(
  parameter int SETTLE_CYCLES = adc_irq_pkg::SETTLE_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // parallel host bus pins
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic bus_width_select,
  input wire logic [4:0] byte_address_lines,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic dataOe_n,
  // sequencer and calibration events, same clock
  input wire logic seqRunning,
  input wire logic [2:0] instrPointer,
  input wire logic fetchStrobe,
  input wire logic [2:0] fetchAddr,
  input wire logic fetchPause,
  input wire logic [4:0] fifoCount,
  input wire logic shortCalDone,
  input wire logic fullCalDone,
  input wire logic configReset,
  input wire logic standbyBit,
  // watchdog comparison, same clock
  input wire logic cmpValid,
  input wire logic signed [8:0] sample,
  input wire logic signed [8:0] limitOne,
  input wire logic dirOne,
  input wire logic signed [8:0] limitTwo,
  input wire logic dirTwo,
  input wire logic [2:0] cmpInstr,
  // supply monitor, asynchronous level
  input wire logic analog_supply_low,
  // outputs to pins
  output logic irqOut_n,
  output logic transfer_request_out
);

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser for every pin input
  localparam int PIN_W = 26;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinMeta_r; // read by the second stage only
  logic [PIN_W-1:0] pinSync_r;

  assign pinRaw = {analog_supply_low, dataIn, byte_address_lines, bus_width_select,
                   writeStrobe_n, readStrobe_n, chipSelect_n};

  // plain shift of both stages; nothing else looks at the first
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pinMeta_r <= adc_irq_pkg::PIN_IDLE;
      pinSync_r <= adc_irq_pkg::PIN_IDLE;
    end
    else
    begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  logic rdAct; // synced read cycle active
  logic wrAct; // synced write cycle active
  logic byteMode; // one selects the eight-bit bus
  logic [4:0] addrSync;
  logic [15:0] dataSync;
  logic supplyLow;

  assign rdAct = !pinSync_r[0] && !pinSync_r[1];
  assign wrAct = !pinSync_r[0] && !pinSync_r[2];
  assign byteMode = pinSync_r[3];
  assign addrSync = pinSync_r[8:4];
  assign dataSync = pinSync_r[24:9];
  assign supplyLow = pinSync_r[25];

  ////////////////////////////////////////////////////////////////////////
  // word address decode, identical for both bus widths
  function automatic logic [3:0] wordAddr(input logic [4:0] a);
    wordAddr = a[4:1]; // [RULE20]
  endfunction : wordAddr

  // byte lane pick on the narrow bus, upper lines read as zero
  function automatic logic [15:0] laneOf(input logic [15:0] w, input logic narrow,
                                         input logic high);
    if (!narrow)
    begin
      laneOf = w;
    end
    else if (high)
    begin
      laneOf = {8'h00, w[15:8]};
    end
    else
    begin
      laneOf = {8'h00, w[7:0]};
    end
  endfunction : laneOf

  ////////////////////////////////////////////////////////////////////////
  // watchdog comparator and limit status word
  logic wdHit;
  logic [15:0] limitStatus;
  logic clearLimit;

  limit_compare u_limit
  (
    .clock(clock),
    .rst_n(rst_n),
    .cmpValid(cmpValid),
    .sample(sample),
    .limitOne(limitOne),
    .dirOne(dirOne),
    .limitTwo(limitTwo),
    .dirTwo(dirTwo),
    .cmpInstr(cmpInstr),
    .clearRead(clearLimit),
    .clearReset(configReset),
    .crossHit(wdHit),
    .limitStatus(limitStatus)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus handshake and register file state
  adc_irq_pkg::bus_state_type busState_r;
  adc_irq_pkg::bus_state_type busState_nxt;
  logic [15:0] enable_r; // mask, match value and fifo threshold
  logic [15:0] enable_nxt;
  logic [4:0] wrAddr_r; // address held across a write strobe
  logic [4:0] wrAddr_nxt;
  logic [15:0] wrData_r; // data held across a write strobe
  logic [15:0] wrData_nxt;
  logic [15:0] dataOut_r;
  logic [15:0] dataOut_nxt;
  logic dataOe_n_r;
  logic dataOe_n_nxt;
  logic clearStatus; // status read that empties the flags
  logic [7:0] flags_r;
  logic [15:0] statusWord;

  // progress fields sit above the flags in the status word
  assign statusWord = {fifoCount, instrPointer, flags_r}; // [RULE17] [RULE18]

  // strobe tracking; a read answers at its start, a write lands at its end
  always_comb
  begin
    busState_nxt = busState_r;
    enable_nxt = enable_r;
    wrAddr_nxt = wrAddr_r;
    wrData_nxt = wrData_r;
    dataOut_nxt = dataOut_r;
    dataOe_n_nxt = dataOe_n_r;
    clearStatus = 1'b0;
    clearLimit = 1'b0;
    case (busState_r)
      adc_irq_pkg::BUS_IDLE:
      begin
        if (rdAct)
        begin
          busState_nxt = adc_irq_pkg::BUS_READ;
          dataOe_n_nxt = 1'b0;
          if (wordAddr(addrSync) == adc_irq_pkg::ENABLE_ADDR)
          begin
            dataOut_nxt = laneOf(enable_r, byteMode, addrSync[0]);
          end
          else if (wordAddr(addrSync) == adc_irq_pkg::STATUS_ADDR)
          begin
            dataOut_nxt = laneOf(statusWord, byteMode, addrSync[0]);
            // narrow bus clears on the upper byte so the low byte survives
            clearStatus = !byteMode || addrSync[0]; // [RULE4]
          end
          else if (wordAddr(addrSync) == adc_irq_pkg::LIMIT_ADDR)
          begin
            dataOut_nxt = laneOf(limitStatus, byteMode, addrSync[0]);
            clearLimit = !byteMode || addrSync[0]; // [RULE7]
          end
          else
          begin
            // other device registers live elsewhere
            dataOut_nxt = adc_irq_pkg::DATA_RESET;
          end
        end
        else if (wrAct)
        begin
          busState_nxt = adc_irq_pkg::BUS_WRITE;
          wrAddr_nxt = addrSync;
          wrData_nxt = dataSync;
        end
      end
      adc_irq_pkg::BUS_READ:
      begin
        // hold the answer until the strobe lets go
        if (!rdAct)
        begin
          busState_nxt = adc_irq_pkg::BUS_IDLE;
          dataOe_n_nxt = 1'b1;
        end
      end
      adc_irq_pkg::BUS_WRITE:
      begin
        if (wrAct)
        begin
          // keep sampling so late-settling data is the one taken
          wrAddr_nxt = addrSync;
          wrData_nxt = dataSync;
        end
        else
        begin
          busState_nxt = adc_irq_pkg::BUS_IDLE;
          if (wordAddr(wrAddr_r) == adc_irq_pkg::ENABLE_ADDR)
          begin
            if (!byteMode)
            begin
              enable_nxt = wrData_r;
            end
            else if (wrAddr_r[0])
            begin
              enable_nxt[15:8] = wrData_r[7:0];
            end
            else
            begin
              enable_nxt[7:0] = wrData_r[7:0];
            end
            // the host is expected to read status next to drop glitches [RULE5]
          end
        end
      end
      default:
      begin
        busState_nxt = adc_irq_pkg::BUS_IDLE;
      end
    endcase
  end

  // register the bus side
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      busState_r <= adc_irq_pkg::BUS_IDLE;
      enable_r <= adc_irq_pkg::ENABLE_RESET;
      wrAddr_r <= 5'h00;
      wrData_r <= adc_irq_pkg::DATA_RESET;
      dataOut_r <= adc_irq_pkg::DATA_RESET;
      dataOe_n_r <= 1'b1;
    end
    else
    begin
      busState_r <= busState_nxt;
      enable_r <= enable_nxt;
      wrAddr_r <= wrAddr_nxt;
      wrData_r <= wrData_nxt;
      dataOut_r <= dataOut_nxt;
      dataOe_n_r <= dataOe_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event sources and sticky flags
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  logic [2:0] matchValue;
  logic [4:0] threshold;
  logic [7:0] events;
  logic [7:0] flags_nxt;
  logic zeroSeen_r; // instruction zero already fetched once
  logic zeroSeen_nxt;
  logic fifoEq_r; // previous fifo equality, for a single event
  logic fifoEq;
  logic standbyPrev_r;
  logic settling_r;
  logic settling_nxt;
  logic [CNT_W-1:0] settleCnt_r;
  logic [CNT_W-1:0] settleCnt_nxt;
  logic wakeEv;
  logic matchEv;
  logic irqOut_n_r;
  logic irqOut_n_nxt;
  logic dmaReq_r;
  logic dmaReq_nxt;

  assign matchValue = enable_r[adc_irq_pkg::MATCH_LSB +: adc_irq_pkg::MATCH_W];
  assign threshold = enable_r[adc_irq_pkg::THRESH_LSB +: adc_irq_pkg::THRESH_W];

  // collect events, fold them into the flags, drive the pins
  always_comb
  begin
    // flag only; the sequencer is never stalled from here [RULE19]
    matchEv = fetchStrobe && (fetchAddr == matchValue) &&
              !((matchValue == 3'h0) && !zeroSeen_r); // [RULE8] [RULE9]
    zeroSeen_nxt = zeroSeen_r;
    if (configReset)
    begin
      zeroSeen_nxt = 1'b0;
    end
    else if (fetchStrobe && (fetchAddr == 3'h0))
    begin
      zeroSeen_nxt = 1'b1; // [RULE9]
    end
    // a zero threshold never fires
    fifoEq = (threshold != 5'h00) && (fifoCount == threshold); // [RULE10]
    // settling count after leaving standby, abandoned if standby returns
    settling_nxt = settling_r;
    settleCnt_nxt = settleCnt_r;
    wakeEv = 1'b0;
    if (standbyBit)
    begin
      settling_nxt = 1'b0;
      settleCnt_nxt = '0;
    end
    else if (standbyPrev_r)
    begin
      settling_nxt = 1'b1;
      settleCnt_nxt = '0;
    end
    else if (settling_r)
    begin
      if (settleCnt_r == CNT_W'(SETTLE_CYCLES - 1))
      begin
        settling_nxt = 1'b0;
        wakeEv = 1'b1; // [RULE15]
      end
      else
      begin
        settleCnt_nxt = settleCnt_r + 1'b1;
      end
    end
    events = '0;
    events[adc_irq_pkg::SRC_WATCHDOG] = wdHit; // [RULE6]
    events[adc_irq_pkg::SRC_MATCH] = matchEv; // [RULE8]
    events[adc_irq_pkg::SRC_FIFO] = fifoEq && !fifoEq_r; // [RULE10]
    events[adc_irq_pkg::SRC_SHORTCAL] = shortCalDone; // [RULE11]
    events[adc_irq_pkg::SRC_FULLCAL] = fullCalDone; // [RULE12]
    events[adc_irq_pkg::SRC_PAUSE] = fetchStrobe && fetchPause; // [RULE13]
    events[adc_irq_pkg::SRC_SUPPLY] = supplyLow; // [RULE14]
    events[adc_irq_pkg::SRC_WAKE] = wakeEv; // [RULE15]
    // clear first, then set: a simultaneous event is kept
    flags_nxt = flags_r;
    if (configReset || clearStatus)
    begin
      flags_nxt = adc_irq_pkg::FLAGS_RESET; // [RULE4] [RULE22]
    end
    flags_nxt = flags_nxt | events; // [RULE3] [RULE24]
    // equal priority: any enabled flag pulls the pin low
    irqOut_n_nxt = !(|(flags_nxt & enable_nxt[7:0])); // [RULE1] [RULE16] [RULE23] [RULE2]
    // request rises on an enabled fifo event, with the pin low, and drops once the fifo is empty
    dmaReq_nxt = dmaReq_r;
    if (configReset || (fifoCount == 5'h00))
    begin
      dmaReq_nxt = 1'b0;
    end
    if (events[adc_irq_pkg::SRC_FIFO] && enable_nxt[adc_irq_pkg::SRC_FIFO])
    begin
      dmaReq_nxt = 1'b1; // [RULE2]
    end
  end

  // register flags and pins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      flags_r <= adc_irq_pkg::FLAGS_RESET;
      zeroSeen_r <= 1'b0;
      fifoEq_r <= 1'b0;
      standbyPrev_r <= 1'b0;
      settling_r <= 1'b0;
      settleCnt_r <= '0;
      irqOut_n_r <= 1'b1;
      dmaReq_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      zeroSeen_r <= zeroSeen_nxt;
      fifoEq_r <= fifoEq;
      standbyPrev_r <= standbyBit;
      settling_r <= settling_nxt;
      settleCnt_r <= settleCnt_nxt;
      irqOut_n_r <= irqOut_n_nxt;
      dmaReq_r <= dmaReq_nxt;
    end
  end

  assign irqOut_n = irqOut_n_r;
  assign transfer_request_out = dmaReq_r;
  assign dataOut = dataOut_r;
  assign dataOe_n = dataOe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_release;
    $fell(standbyBit);
  endsequence

  sequence s_quiet8;
    !wakeEv [*8];
  endsequence

  a_pin_follows_flags: assert property ( // [RULE23]
    ##1 (irqOut_n == !(|(flags_r & enable_r[7:0]))))
    else $error("interrupt pin disagrees with enabled flags");

  a_dma_with_pin: assert property ( // [RULE2]
    $rose(transfer_request_out) |-> !irqOut_n)
    else $error("transfer request rose without interrupt low");

  a_event_sets_flag: assert property ( // [RULE3]
    (events != 8'h00) |=> ((flags_r & $past(events)) == $past(events)))
    else $error("event did not set its flag");

  a_read_clears: assert property ( // [RULE4]
    (clearStatus && !configReset && (events == 8'h00)) |=> (flags_r == 8'h00))
    else $error("status read left flags set");

  a_reset_clears: assert property ( // [RULE22]
    (configReset && !cmpValid && events == 8'h00) |=> flags_r == 8'h00 && limitStatus == 16'h0000)
    else $error("configuration reset left flags set");

  a_match_sets: assert property ( // [RULE8]
    (fetchStrobe && (fetchAddr == matchValue) && (matchValue != 3'h0)) |=> flags_r[1])
    else $error("pointer match missed");

  a_zero_first_skip: assert property ( // [RULE9]
    (fetchStrobe && (fetchAddr == 3'h0) && (matchValue == 3'h0) && !zeroSeen_r &&
     !flags_r[1]) |=> !flags_r[1])
    else $error("first fetch of zero raised match");

  a_wake_delay: assert property ( // [RULE15]
    s_release |-> s_quiet8)
    else $error("wake flag before settling");

  a_progress_read: assert property ( // [RULE17]
    (busState_r == adc_irq_pkg::BUS_IDLE && rdAct && !byteMode &&
     wordAddr(addrSync) == adc_irq_pkg::STATUS_ADDR) |=>
    (dataOut[15:8] == $past({fifoCount, instrPointer})) && !dataOe_n)
    else $error("status read lost pointer or count");

endmodule : adc_interrupt_unit
`default_nettype wire

// File: verification/host_bus_model.sv
// host processor model that drives the converter's parallel register bus
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
(
  // clock
  input wire logic clock,
  // bus pins toward the unit
  output logic chipSelect_n,
  output logic readStrobe_n,
  output logic writeStrobe_n,
  output logic [4:0] byte_address_lines,
  output logic [15:0] dataIn,
  // read data from the unit
  input wire logic [15:0] dataOut,
  input wire logic dataOe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // idle bus: strobes high, data lines carry a pattern, not a stale word
  initial
  begin
    chipSelect_n = 1'b1;
    readStrobe_n = 1'b1;
    writeStrobe_n = 1'b1;
    byte_address_lines = 5'h00;
    dataIn = 16'hA5A5;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read one word; strobes stay low until the unit drives the bus or the twelve-cycle wait runs out
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int k;
    @(posedge clock);
    chipSelect_n <= 1'b0;
    readStrobe_n <= 1'b0;
    byte_address_lines <= a;
    k = 0;
    while (dataOe_n !== 1'b0 && k < 12)
    begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
    d = dataOe_n ? 16'hDEAD : dataOut;
    chipSelect_n <= 1'b1;
    readStrobe_n <= 1'b1;
    byte_address_lines <= ~a;
    // recovery: the unit ignores strobes until the access has ended
    repeat (5) @(posedge clock);
  endtask : rd

  // write one word; data held well past the strobe rise, then scrambled
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    chipSelect_n <= 1'b0;
    writeStrobe_n <= 1'b0;
    byte_address_lines <= a;
    dataIn <= d;
    repeat (3) @(posedge clock);
    chipSelect_n <= 1'b1;
    writeStrobe_n <= 1'b1;
    repeat (6) @(posedge clock);
    dataIn <= ~d;
    byte_address_lines <= ~a;
  endtask : wr

endmodule : host_bus_model
`default_nettype wire

// File: verification/adc_interrupt_unit_bench.sv
// self-checking bench for the converter interrupt unit
`timescale 1ns/1ps
`default_nettype none

module adc_interrupt_unit_bench;

  // clock, reset and every design pin
  logic clock, rst_n;
  logic chipSelect_n, readStrobe_n, writeStrobe_n, bus_width_select;
  logic [4:0] byte_address_lines, fifoCount;
  logic [15:0] dataIn, dataOut;
  logic dataOe_n, irqOut_n, transfer_request_out, seqRunning;
  logic fetchStrobe, fetchPause, shortCalDone, fullCalDone, configReset;
  logic standbyBit, cmpValid, dirOne, dirTwo, analog_supply_low;
  logic [2:0] instrPointer, fetchAddr, cmpInstr;
  logic signed [8:0] sample, limitOne, limitTwo;
  // counters for the verdict and the hang guard
  int mismatches, nChecks, cycles;

  ////////////////////////////////////////////////////////////////////////////
  // short settling count keeps the wake-up test brief
  adc_interrupt_unit #(.SETTLE_CYCLES(20)) dut_u
  (
    .clock, .rst_n, .chipSelect_n, .readStrobe_n, .writeStrobe_n,
    .bus_width_select, .byte_address_lines, .dataIn, .dataOut, .dataOe_n,
    .seqRunning, .instrPointer, .fetchStrobe, .fetchAddr, .fetchPause,
    .fifoCount, .shortCalDone, .fullCalDone, .configReset, .standbyBit,
    .cmpValid, .sample, .limitOne, .dirOne, .limitTwo, .dirTwo, .cmpInstr,
    .analog_supply_low, .irqOut_n, .transfer_request_out
  );

  host_bus_model host_u
  (
    .clock, .chipSelect_n, .readStrobe_n, .writeStrobe_n,
    .byte_address_lines, .dataIn, .dataOut, .dataOe_n
  );

  always #50 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // expected status word: fifo count, pointer, flags
  function automatic logic [15:0] stat(input logic [7:0] f);
    return {fifoCount, instrPointer, f};
  endfunction : stat

  task automatic rdChk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host_u.rd(a, d);
    check(d, exp);
  endtask : rdChk

  // enable write followed by the discarding status read
  task automatic setEnable(input logic [15:0] v);
    logic [15:0] d;
    host_u.wr(5'h12, v);
    host_u.rd(5'h14, d);
  endtask : setEnable

  task automatic evt(input logic [1:0] w);
    @(posedge clock);
    shortCalDone <= w[0];
    fullCalDone <= w[1];
    @(posedge clock);
    shortCalDone <= 1'b0;
    fullCalDone <= 1'b0;
  endtask : evt

  task automatic fetch(input logic [2:0] a, input logic p);
    @(posedge clock);
    fetchStrobe <= 1'b1;
    fetchAddr <= a;
    fetchPause <= p;
    @(posedge clock);
    fetchStrobe <= 1'b0;
    fetchPause <= 1'b0;
  endtask : fetch

  task automatic wd(input logic [2:0] n, input logic [8:0] l1, input logic d1,
                    input logic [8:0] l2, input logic d2, input logic [15:0] exp);
    @(posedge clock);
    cmpValid <= 1'b1;
    sample <= 9'h032;
    limitOne <= l1;
    dirOne <= d1;
    limitTwo <= l2;
    dirTwo <= d2;
    cmpInstr <= n;
    @(posedge clock);
    cmpValid <= 1'b0;
    rdChk(5'h1A, exp);
    rdChk(5'h14, stat(8'h01));
  endtask : wd

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic tReset;
    @(negedge clock);
    check({14'h0, irqOut_n, transfer_request_out}, 16'h0002);
    rdChk(5'h12, 16'h0000);
    rdChk(5'h00, 16'h0000);
    rdChk(5'h14, stat(8'h00));
  endtask : tReset

  // masked sources still latch their flags, and a read clears them
  task automatic tFlags;
    fetch(3'h3, 1'b1);
    evt(2'b11);
    @(negedge clock);
    check({15'h0, irqOut_n}, 16'h0001);
    rdChk(5'h14, stat(8'h38));
    rdChk(5'h14, stat(8'h00));
  endtask : tFlags

  task automatic tIrq;
    setEnable(16'h0010);
    evt(2'b11);
    @(negedge clock);
    check({15'h0, irqOut_n}, 16'h0000);
    rdChk(5'h14, stat(8'h18));
    check({15'h0, irqOut_n}, 16'h0001);
  endtask : tIrq

  // match value zero: first fetch of instruction zero is skipped
  task automatic tMatch;
    @(posedge clock);
    configReset <= 1'b1;
    @(posedge clock);
    configReset <= 1'b0;
    setEnable(16'h0002);
    fetch(3'h0, 1'b0);
    @(negedge clock);
    check({15'h0, irqOut_n}, 16'h0001);
    fetch(3'h0, 1'b0);
    @(negedge clock);
    check({15'h0, irqOut_n}, 16'h0000);
    rdChk(5'h14, stat(8'h02));
  endtask : tMatch

  // threshold of four: pin and transfer request assert together; the request drops once the fifo is empty
  task automatic tFifo;
    setEnable(16'h2004);
    @(posedge clock);
    fifoCount <= 5'h03;
    @(posedge clock);
    fifoCount <= 5'h04;
    @(negedge clock);
    check({14'h0, irqOut_n, transfer_request_out}, 16'h0002);
    @(negedge clock);
    check({14'h0, irqOut_n, transfer_request_out}, 16'h0001);
    rdChk(5'h14, stat(8'h04));
    @(posedge clock);
    fifoCount <= 5'h00;
    repeat (2) @(negedge clock);
    check({15'h0, transfer_request_out}, 16'h0000);
  endtask : tFifo

  task automatic tSupply;
    @(posedge clock);
    analog_supply_low <= 1'b1;
    repeat (4) @(posedge clock);
    analog_supply_low <= 1'b0;
    repeat (4) @(posedge clock);
    rdChk(5'h14, stat(8'h40));
    rdChk(5'h14, stat(8'h00));
  endtask : tSupply

  // wake flag appears only after the settling count
  task automatic tWake;
    @(posedge clock);
    standbyBit <= 1'b1;
    repeat (3) @(posedge clock);
    standbyBit <= 1'b0;
    rdChk(5'h14, stat(8'h00));
    repeat (25) @(posedge clock);
    rdChk(5'h14, stat(8'h80));
  endtask : tWake

  // eight-bit bus: one lane per access, flags clear on the high byte
  task automatic tByte;
    @(posedge clock);
    bus_width_select <= 1'b1;
    repeat (3) @(posedge clock);
    host_u.wr(5'h13, 16'h0021);
    rdChk(5'h13, 16'h0021);
    rdChk(5'h12, 16'h0004);
    evt(2'b01);
    rdChk(5'h14, 16'h0008);
    rdChk(5'h15, {8'h00, fifoCount, instrPointer});
    rdChk(5'h14, 16'h0000);
    @(posedge clock);
    bus_width_select <= 1'b0;
  endtask : tByte

  task automatic tCfgReset;
    evt(2'b01);
    @(posedge clock);
    configReset <= 1'b1;
    @(posedge clock);
    configReset <= 1'b0;
    rdChk(5'h14, stat(8'h00));
  endtask : tCfgReset

  ////////////////////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic close_out;
    $display("checks %0d, mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      close_out();
    end
  end

  // main sequence: every input given a value at time zero
  initial
  begin
    {clock, rst_n, bus_width_select, fetchStrobe, fetchPause} = 5'h00;
    {shortCalDone, fullCalDone, configReset, standbyBit, cmpValid} = 5'h00;
    {dirOne, dirTwo, analog_supply_low} = 3'h0;
    seqRunning = 1'b1;
    {instrPointer, fetchAddr, cmpInstr, fifoCount} = 14'h2800;
    {sample, limitOne, limitTwo} = 27'h0000000;
    {mismatches, nChecks, cycles} = 96'h0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    tReset();
    tFlags();
    tIrq();
    tMatch();
    tFifo();
    wd(3'h3, 9'h014, 1'b1, 9'h064, 1'b1, 16'h0008);
    wd(3'h6, 9'h1EC, 1'b0, 9'h064, 1'b0, 16'h4000);
    tSupply();
    tWake();
    tByte();
    tCfgReset();
    close_out();
  end

endmodule : adc_interrupt_unit_bench
`default_nettype wire
